/* logic/spb_pkg.sv */
// Purpose: Shared constants and types for the serial port register banks.
// Assumes: Byte wide host I/O cycles on the 40 MHz system clock.
// Notes: Behaviour list below; numbers are used by name only.
//
// Behaviour
// - Four banks of eight registers all decode into the same window of offsets 0 to 7.
// - The bank selector is written and read at offset 3 whatever bank is active.
// - A byte written at offset 3 with its top bit set selects a bank and leaves the line parameters unchanged.
// - Top bit 0 gives bank 0, top bits 10 or 11 with bit 1 or 0 set give bank 1, e0 gives bank 2, e4 gives bank 3.
// - In bank 0 at offset 2 a read returns event identification and a write updates FIFO control.
// - Bank 0 offset 7 is scratch data in the standard mode and aux status and control in extended mode.
// - Bank 1 holds the legacy divisor low and high bytes at offsets 0 and 1, the rest being reserved.
// - Bank 2 holds divisor bytes, two extended controls and the transmit and receive FIFO levels at 6 and 7.
// - Bank 3 offset 0 reads a module code in bits 7-4 and a revision code in bits 3-0.
// - Bank 3 offsets 1 and 2 read back the line control and FIFO control settings.
// - The port works as a standard compatible UART or in an extended mode that changes some layouts.
// - A read-only location that shares its offset with a write register sends writes to that register.
package spb_pkg;
    // Offsets within the eight byte window.
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_EVT = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_AUX = 3'h7;
    localparam logic [2:0] OFS_DIV_HI = 3'h1;
    localparam logic [2:0] OFS_EXC1 = 3'h2;
    localparam logic [2:0] OFS_EXC2 = 3'h4;
    localparam logic [2:0] OFS_TRANSMIT_FIFO_LEVEL = 3'h6;
    localparam logic [2:0] OFS_RECEIVE_FIFO_LEVEL = 3'h7;
    localparam logic [2:0] OFS_MODULE_REVISION_CODE = 3'h0;
    localparam logic [2:0] OFS_LINE_CONTROL_MIRROR = 3'h1;
    localparam logic [2:0] OFS_FIFO_CONTROL_MIRROR = 3'h2;
    // Bank selector field positions and codes.
    localparam int BANK_SELECT_ENABLE_BIT = 7;
    localparam int BSEL_HI_BIT = 6;
    localparam logic [7:0] BANK2_CODE = 8'he0;
    localparam logic [7:0] BANK3_CODE = 8'he4;
    // Control bit positions.
    localparam int EXT_SL_BIT = 0;
    localparam int FCR_TXSR_BIT = 2;
    localparam int FCR_RXSR_BIT = 1;
    localparam int AUX_RXF_BIT = 0;
    // Readable bits of mode dependent registers, stored FIFO control bits and the level field.
    localparam logic [7:0] IER_MASK_STD = 8'h0f;
    localparam logic [7:0] IER_MASK_EXT = 8'h2f;
    localparam logic [7:0] MCR_MASK_STD = 8'h1f;
    localparam logic [7:0] MCR_MASK_EXT = 8'h0b;
    localparam logic [7:0] AUX_MASK_EXT = 8'h01;
    localparam logic [7:0] FCR_STORE_MASK = 8'hf1;
    localparam logic [4:0] LEVEL_MASK = 5'h1f;
    // Reset values.
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;
    // Identity nibbles; values are arbitrary.
    localparam logic [3:0] MODULE_CODE = 4'h5;
    localparam logic [3:0] REVISION_CODE = 4'h1;
    // Transmit FIFO shape.
    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 8;
    typedef enum logic [1:0] {SPB_BANK0, SPB_BANK1, SPB_BANK2, SPB_BANK3} spb_bank_t;
endpackage

/* logic/spb_bank_if.sv */
// Purpose: Carries the selector byte and its decoded bank.
// Assumes: One clock domain.
// Notes: Decoder drives the bank, the register file drives the selector.
`timescale 1ns/1ps
interface spb_bank_if;
    logic [7:0] sel;
    spb_pkg::spb_bank_t bank;
    logic bank_ok;
    modport dec (input sel, output bank, output bank_ok);
    modport user (output sel, input bank, input bank_ok);
endinterface

/* logic/spb_bank_dec.sv */
// Purpose: Decodes the line control and bank selector byte into a bank.
// Assumes: Selector byte comes from a flip-flop.
// Notes: Codes outside the table select no bank; then only offset 3 is mapped and other offsets read zero.
`timescale 1ns/1ps
module spb_bank_dec (
    spb_bank_if.dec bif
);
    // Bank decode in priority order of the encoding table.
    always_comb begin
        bif.bank = spb_pkg::SPB_BANK0;
        bif.bank_ok = 1'b1;
        if (!bif.sel[spb_pkg::BANK_SELECT_ENABLE_BIT]) begin
            bif.bank = spb_pkg::SPB_BANK0;
        end else if (!bif.sel[spb_pkg::BSEL_HI_BIT] || bif.sel[1] || bif.sel[0]) begin
            bif.bank = spb_pkg::SPB_BANK1;
        end else if (bif.sel == spb_pkg::BANK2_CODE) begin
            bif.bank = spb_pkg::SPB_BANK2;
        end else if (bif.sel == spb_pkg::BANK3_CODE) begin
            bif.bank = spb_pkg::SPB_BANK3;
        end else begin
            bif.bank_ok = 1'b0;
        end
    end
endmodule

/* logic/spb_fifo.sv */
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: Single clock; flush drops every entry.
// Notes: Full and empty are held in flip-flops.
`timescale 1ns/1ps
module spb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic full_r, full_nxt, empty_r, empty_nxt;
    logic push, pop;

    // Handshake terms and pointer arithmetic.
    always_comb begin
        push = in_valid && !full_r;
        pop = out_ready && !empty_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
        full_nxt = (cnt_nxt == CW'(DEPTH));
        empty_nxt = (cnt_nxt == '0);
    end

    // State registers; the store keeps data without reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            empty_r <= empty_nxt;
        end
    end

    // Storage write.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    assign in_ready = !full_r;
    assign out_valid = !empty_r;
    assign out_data = mem_r[rp_r];
    assign full = full_r;
    assign level = cnt_r;
endmodule

/* logic/spb_regs.sv */
// Purpose: Register bank front end of one serial port.
// Assumes: Host strobes are one-cycle pulses on clk; engine signals share clk.
// Notes: Transmit bytes pass an eight entry FIFO and an output stage.
`timescale 1ns/1ps
module spb_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_rd,
    output logic [7:0] host_rdata,
    output logic host_rdata_valid,
    output logic host_tx_full,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] event_id,
    input wire logic [7:0] link_status,
    input wire logic [7:0] modem_status,
    input wire logic rx_timeout,
    input wire logic [4:0] rx_level,
    output logic rx_pop,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic tx_fifo_reset,
    output logic rx_fifo_reset,
    output logic [7:0] line_params,
    output logic [7:0] interrupt_enables,
    output logic [7:0] modem_mode_control,
    output logic [7:0] fifo_control,
    output logic [15:0] baud_divisor,
    output logic [7:0] extended_control_one,
    output logic [7:0] extended_control_two,
    output logic [7:0] aux_status_control
);
    localparam int LW = $clog2(spb_pkg::TX_FIFO_DEPTH + 1);

    logic [7:0] sel_r, sel_nxt, lp_r, lp_nxt, ier_r, ier_nxt, mcr_r, mcr_nxt;
    logic [7:0] fcr_r, fcr_nxt, scr_r, scr_nxt, aux_r, aux_nxt;
    logic [7:0] exc1_r, exc1_nxt, exc2_r, exc2_nxt;
    logic [15:0] div_r, div_nxt;
    logic [7:0] rdata_r, rdata_nxt, txd_r, txd_nxt;
    logic rvalid_r, rvalid_nxt, pop_r, pop_nxt, txv_r, txv_nxt;
    logic txsr_r, txsr_nxt, rxsr_r, rxsr_nxt;
    logic ext_mode;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_full;
    logic [7:0] f_out_data;
    logic [LW-1:0] f_level;

    spb_bank_if bif();

    // Masks a value down to the bits defined in the active mode.
    function automatic logic [7:0] mode_mask(input logic ext, input logic [7:0] v,
                                             input logic [7:0] m_std, input logic [7:0] m_ext);
        mode_mask = v & (ext ? m_ext : m_std);
    endfunction

    // Selector byte feeds the bank decoder.
    assign bif.sel = sel_r;
    assign ext_mode = exc1_r[spb_pkg::EXT_SL_BIT];

    spb_bank_dec u_dec (
        .bif(bif)
    );

    spb_fifo #(
        .WIDTH(spb_pkg::TX_FIFO_WIDTH),
        .DEPTH(spb_pkg::TX_FIFO_DEPTH)
    ) u_txq (
        .clk(clk),
        .rst(rst),
        .flush(txsr_r),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(host_wdata),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data),
        .full(f_full),
        .level(f_level)
    );

    // Output stage takes a byte whenever it is empty or being drained.
    assign f_out_ready = !txv_r || tx_ready;
    // Transmit data push; a write while the queue is full is dropped.
    assign f_in_valid = host_wr && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK0
                        && host_addr == spb_pkg::OFS_DATA && f_in_ready;

    // Next values of every register, for host writes, reads and the output stage.
    always_comb begin
        sel_nxt = sel_r;
        lp_nxt = lp_r;
        ier_nxt = ier_r;
        mcr_nxt = mcr_r;
        fcr_nxt = fcr_r;
        scr_nxt = scr_r;
        aux_nxt = aux_r;
        exc1_nxt = exc1_r;
        exc2_nxt = exc2_r;
        div_nxt = div_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        pop_nxt = 1'b0;
        txsr_nxt = 1'b0;
        rxsr_nxt = 1'b0;
        txv_nxt = txv_r;
        txd_nxt = txd_r;
        if (f_out_ready) begin
            txv_nxt = f_out_valid;
            txd_nxt = f_out_data;
        end
        if (txsr_r) begin
            txv_nxt = 1'b0;
        end
        // Host writes; every bank shares the same eight offsets.
        if (host_wr) begin
            if (host_addr == spb_pkg::OFS_LCR) begin
                sel_nxt = host_wdata;
                if (!host_wdata[spb_pkg::BANK_SELECT_ENABLE_BIT]) begin
                    lp_nxt = host_wdata;
                end
            end else if (bif.bank_ok) begin
                unique case (bif.bank)
                    spb_pkg::SPB_BANK0: begin
                        unique case (host_addr)
                            spb_pkg::OFS_IER: ier_nxt = host_wdata;
                            spb_pkg::OFS_EVT: begin
                                fcr_nxt = host_wdata & spb_pkg::FCR_STORE_MASK;
                                txsr_nxt = host_wdata[spb_pkg::FCR_TXSR_BIT];
                                rxsr_nxt = host_wdata[spb_pkg::FCR_RXSR_BIT];
                            end
                            spb_pkg::OFS_MCR: mcr_nxt = host_wdata;
                            spb_pkg::OFS_AUX: begin
                                if (ext_mode) begin
                                    aux_nxt = host_wdata;
                                end else begin
                                    scr_nxt = host_wdata;
                                end
                            end
                            default: ;
                        endcase
                    end
                    spb_pkg::SPB_BANK1: begin
                        if (host_addr == spb_pkg::OFS_DATA) begin
                            div_nxt[7:0] = host_wdata;
                        end else if (host_addr == spb_pkg::OFS_DIV_HI) begin
                            div_nxt[15:8] = host_wdata;
                        end
                    end
                    spb_pkg::SPB_BANK2: begin
                        unique case (host_addr)
                            spb_pkg::OFS_DATA: div_nxt[7:0] = host_wdata;
                            spb_pkg::OFS_DIV_HI: div_nxt[15:8] = host_wdata;
                            spb_pkg::OFS_EXC1: exc1_nxt = host_wdata;
                            spb_pkg::OFS_EXC2: exc2_nxt = host_wdata;
                            default: ;
                        endcase
                    end
                    spb_pkg::SPB_BANK3: ; // Read-only bank, writes fall away.
                endcase
            end
        end
        // Host reads; unmapped and reserved locations answer zero.
        if (host_rd) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = spb_pkg::BYTE_RST;
            if (host_addr == spb_pkg::OFS_LCR) begin
                rdata_nxt = sel_r;
            end else if (bif.bank_ok) begin
                unique case (bif.bank)
                    spb_pkg::SPB_BANK0: begin
                        unique case (host_addr)
                            spb_pkg::OFS_DATA: begin
                                rdata_nxt = rx_data;
                                pop_nxt = 1'b1;
                            end
                            spb_pkg::OFS_IER: rdata_nxt = mode_mask(ext_mode, ier_r,
                                spb_pkg::IER_MASK_STD, spb_pkg::IER_MASK_EXT);
                            spb_pkg::OFS_EVT: rdata_nxt = event_id;
                            spb_pkg::OFS_MCR: rdata_nxt = mode_mask(ext_mode, mcr_r,
                                spb_pkg::MCR_MASK_STD, spb_pkg::MCR_MASK_EXT);
                            spb_pkg::OFS_LSR: rdata_nxt = link_status;
                            spb_pkg::OFS_MSR: rdata_nxt = modem_status;
                            spb_pkg::OFS_AUX: begin
                                if (ext_mode) begin
                                    rdata_nxt = {7'h00, rx_timeout} & spb_pkg::AUX_MASK_EXT;
                                end else begin
                                    rdata_nxt = scr_r;
                                end
                            end
                            default: ;
                        endcase
                    end
                    spb_pkg::SPB_BANK1: begin
                        if (host_addr == spb_pkg::OFS_DATA) begin
                            rdata_nxt = div_r[7:0];
                        end else if (host_addr == spb_pkg::OFS_DIV_HI) begin
                            rdata_nxt = div_r[15:8];
                        end
                    end
                    spb_pkg::SPB_BANK2: begin
                        unique case (host_addr)
                            spb_pkg::OFS_DATA: rdata_nxt = div_r[7:0];
                            spb_pkg::OFS_DIV_HI: rdata_nxt = div_r[15:8];
                            spb_pkg::OFS_EXC1: rdata_nxt = exc1_r;
                            spb_pkg::OFS_EXC2: rdata_nxt = exc2_r;
                            spb_pkg::OFS_TRANSMIT_FIFO_LEVEL: rdata_nxt = {3'h0, 5'(f_level) & spb_pkg::LEVEL_MASK};
                            spb_pkg::OFS_RECEIVE_FIFO_LEVEL: rdata_nxt = {3'h0, rx_level};
                            default: ;
                        endcase
                    end
                    spb_pkg::SPB_BANK3: begin
                        unique case (host_addr)
                            spb_pkg::OFS_MODULE_REVISION_CODE: rdata_nxt = {spb_pkg::MODULE_CODE,
                                                            spb_pkg::REVISION_CODE};
                            spb_pkg::OFS_LINE_CONTROL_MIRROR: rdata_nxt = sel_r;
                            spb_pkg::OFS_FIFO_CONTROL_MIRROR: rdata_nxt = fcr_r;
                            default: ;
                        endcase
                    end
                endcase
            end
        end
    end

    // Register stage; reset brings bank 0 and line control into view.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= spb_pkg::BYTE_RST;
            lp_r <= spb_pkg::BYTE_RST;
            ier_r <= spb_pkg::BYTE_RST;
            mcr_r <= spb_pkg::BYTE_RST;
            fcr_r <= spb_pkg::BYTE_RST;
            scr_r <= spb_pkg::BYTE_RST;
            aux_r <= spb_pkg::BYTE_RST;
            exc1_r <= spb_pkg::BYTE_RST;
            exc2_r <= spb_pkg::BYTE_RST;
            div_r <= spb_pkg::DIV_RST;
            rdata_r <= spb_pkg::BYTE_RST;
            rvalid_r <= 1'b0;
            pop_r <= 1'b0;
            txsr_r <= 1'b0;
            rxsr_r <= 1'b0;
            txv_r <= 1'b0;
            txd_r <= spb_pkg::BYTE_RST;
        end else begin
            sel_r <= sel_nxt;
            lp_r <= lp_nxt;
            ier_r <= ier_nxt;
            mcr_r <= mcr_nxt;
            fcr_r <= fcr_nxt;
            scr_r <= scr_nxt;
            aux_r <= aux_nxt;
            exc1_r <= exc1_nxt;
            exc2_r <= exc2_nxt;
            div_r <= div_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            pop_r <= pop_nxt;
            txsr_r <= txsr_nxt;
            rxsr_r <= rxsr_nxt;
            txv_r <= txv_nxt;
            txd_r <= txd_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign host_rdata = rdata_r;
    assign host_rdata_valid = rvalid_r;
    assign host_tx_full = f_full;
    assign rx_pop = pop_r;
    assign tx_valid = txv_r;
    assign tx_data = txd_r;
    assign tx_fifo_reset = txsr_r;
    assign rx_fifo_reset = rxsr_r;
    assign line_params = lp_r;
    assign interrupt_enables = ier_r;
    assign modem_mode_control = mcr_r;
    assign fifo_control = fcr_r;
    assign baud_divisor = div_r;
    assign extended_control_one = exc1_r;
    assign extended_control_two = exc2_r;
    assign aux_status_control = aux_r;

    // Checks on the register file behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sel_any_bank: assert property (host_wr && host_addr == spb_pkg::OFS_LCR
        |=> sel_r == $past(host_wdata)) else $error("selector write lost");
    a_bank_sel_keeps: assert property (host_wr && host_addr == spb_pkg::OFS_LCR
        && host_wdata[spb_pkg::BANK_SELECT_ENABLE_BIT] |=> $stable(lp_r)) else $error("bank select changed line params");
    a_bank_zero_decode: assert property (!sel_r[spb_pkg::BANK_SELECT_ENABLE_BIT]
        |-> bif.bank == spb_pkg::SPB_BANK0 && bif.bank_ok) else $error("bank 0 decode wrong");
    a_bank_two_decode: assert property (sel_r == spb_pkg::BANK2_CODE
        |-> bif.bank == spb_pkg::SPB_BANK2) else $error("bank 2 decode wrong");
    a_rx_read_pop: assert property (host_rd && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK0
        && host_addr == spb_pkg::OFS_DATA |=> rx_pop && host_rdata == $past(rx_data)
        ##1 (!rx_pop || $past(host_rd && host_addr == spb_pkg::OFS_DATA))) // Back to back reads keep the pop up.
        else $error("receive read wrong");
    a_fcr_shadow: assert property (host_wr && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK0
        && host_addr == spb_pkg::OFS_EVT |=> fifo_control == ($past(host_wdata) & spb_pkg::FCR_STORE_MASK)
        && tx_fifo_reset == $past(host_wdata[spb_pkg::FCR_TXSR_BIT])) else $error("fifo control wrong");
    a_ident_read: assert property (host_rd && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK3
        && host_addr == spb_pkg::OFS_MODULE_REVISION_CODE |=> host_rdata == {spb_pkg::MODULE_CODE, spb_pkg::REVISION_CODE})
        else $error("identity read wrong");
    a_reserved_zero: assert property (host_rd && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK1
        && host_addr == spb_pkg::OFS_EVT |=> host_rdata == spb_pkg::BYTE_RST) else $error("reserved not zero");
    a_divisor_write: assert property (host_wr && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK1
        && host_addr == spb_pkg::OFS_DIV_HI |=> baud_divisor[15:8] == $past(host_wdata))
        else $error("divisor high write lost");
    a_read_answer: assert property (host_rd |=> host_rdata_valid ##1 !host_rdata_valid || $past(host_rd))
        else $error("read answer timing wrong");
    // Line parameters, remaining bank codes, the FIFO control mirror, scratch, aux status and the transmit hold.
    a_line_write: assert property (host_wr && host_addr == spb_pkg::OFS_LCR
        && !host_wdata[spb_pkg::BANK_SELECT_ENABLE_BIT] |=> line_params == $past(host_wdata))
        else $error("line params lost");
    a_bank_one_decode: assert property (sel_r[spb_pkg::BANK_SELECT_ENABLE_BIT]
        && (!sel_r[spb_pkg::BSEL_HI_BIT] || sel_r[1] || sel_r[0]) |-> bif.bank == spb_pkg::SPB_BANK1 && bif.bank_ok)
        else $error("bank 1 decode wrong");
    a_bank_three_decode: assert property (sel_r == spb_pkg::BANK3_CODE
        |-> bif.bank == spb_pkg::SPB_BANK3 && bif.bank_ok) else $error("bank 3 decode wrong");
    a_mirror_read: assert property (host_rd && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK3
        && host_addr == spb_pkg::OFS_FIFO_CONTROL_MIRROR |=> host_rdata == $past(fcr_r))
        else $error("fifo control mirror wrong");
    a_bank_three_ro: assert property (host_wr && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK3
        && host_addr != spb_pkg::OFS_LCR |=> $stable(fcr_r) && $stable(div_r) && $stable(exc1_r))
        else $error("read-only bank written");
    a_scratch_write: assert property (host_wr && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK0
        && host_addr == spb_pkg::OFS_AUX && !ext_mode |=> scr_r == $past(host_wdata))
        else $error("scratch write lost");
    a_aux_read: assert property (host_rd && bif.bank_ok && bif.bank == spb_pkg::SPB_BANK0
        && host_addr == spb_pkg::OFS_AUX && ext_mode |=> host_rdata == {7'h00, $past(rx_timeout)})
        else $error("aux status read wrong");
    a_tx_hold: assert property (tx_valid && !tx_ready && !tx_fifo_reset
        |=> tx_valid && $stable(tx_data)) else $error("transmit byte not held");

    c_bank_two: cover property (host_wr && host_addr == spb_pkg::OFS_LCR && host_wdata == spb_pkg::BANK2_CODE);
    c_tx_drain: cover property (tx_valid && tx_ready);
    c_queue_full: cover property (host_tx_full ##[1:20] !host_tx_full);

    // Extended mode status read and the read-only bank.
    c_ext_aux: cover property (ext_mode && host_rd && host_addr == spb_pkg::OFS_AUX);
    c_bank_three: cover property (bif.bank_ok && bif.bank == spb_pkg::SPB_BANK3 && host_rd);
endmodule

/* tb/spb_engine_model.sv */
// Purpose: Serial engine stand-in facing the transmit side of the register banks.
// Assumes: A byte is taken on a rising edge with valid and ready both high.
// Notes: In slow mode ready comes only one cycle in four.
`timescale 1ns/1ps
module spb_engine_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic [7:0] last_tx
);
    logic [1:0] cnt = 2'h0;
    // Counts the stall pattern and keeps the last byte accepted.
    always @(posedge clk) begin
        cnt <= cnt + 2'h1;
        if (tx_valid && tx_ready) begin
            last_tx <= tx_data;
        end
    end
    // Ready is prompt or held back to stall the queue.
    assign tx_ready = !slow || (cnt == 2'h3);
endmodule

/* tb/spb_regs_tb.sv */
// Purpose: Self-checking bench for the serial port register banks.
// Assumes: Host strobes are one-cycle pulses driven at the falling edge.
// Notes: Engine status inputs other than the timeout hold fixed patterns that reads must return.
`timescale 1ns/1ps
module spb_regs_tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0, slow = 1'b0, tout = 1'b0, vld, full, ready, txv;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00, rdat, txd, last_tx, lp, fc, ien, mmc, ex1, aux;
    logic [15:0] div;
    int err_total = 0, n_checks = 0;
    // Clock of 25 ns period.
    always #12.5 clk = ~clk;
    spb_regs dut (.clk(clk), .rst(rst), .host_addr(addr), .host_wdata(wd), .host_wr(wr), .host_rd(rd_s),
        .host_rdata(rdat), .host_rdata_valid(vld), .host_tx_full(full), .rx_data(8'h3c), .event_id(8'h5a),
        .link_status(8'h60), .modem_status(8'hb0), .rx_timeout(tout), .rx_level(5'h03), .rx_pop(),
        .tx_valid(txv), .tx_data(txd), .tx_ready(ready), .tx_fifo_reset(), .rx_fifo_reset(),
        .line_params(lp), .interrupt_enables(ien), .modem_mode_control(mmc), .fifo_control(fc),
        .baud_divisor(div), .extended_control_one(ex1), .extended_control_two(), .aux_status_control(aux));
    spb_engine_model eng (.clk(clk), .slow(slow), .tx_valid(txv), .tx_data(txd), .tx_ready(ready),
        .last_tx(last_tx));
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One write strobe.
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        addr = a; wd = d; wr = 1'b1;
        @(negedge clk) wr = 1'b0;
        @(negedge clk);
    endtask
    // One read strobe; data is judged in the cycle in which the answer stands.
    task automatic hr(input logic [2:0] a, input logic [7:0] exp);
        addr = a; rd_s = 1'b1;
        @(negedge clk) rd_s = 1'b0;
        chk({7'h00, vld, rdat}, {8'h01, exp});
        @(negedge clk);
    endtask
    // Reset state and bank 0 read paths.
    task automatic t_bank0;
        hr(3'h3, 8'h00);
        hr(3'h0, 8'h3c);
        hr(3'h2, 8'h5a);
        hr(3'h5, 8'h60);
        hr(3'h6, 8'hb0);
        hw(3'h2, 8'hc7);
        chk(fc, 8'hc1);
    endtask
    // Bank switching, divisor aliasing, reserved places and identity.
    task automatic t_banks;
        hw(3'h3, 8'h1b);
        hw(3'h3, 8'he0);
        chk(lp, 8'h1b);
        hw(3'h0, 8'h34);
        hw(3'h1, 8'h12);
        chk(div, 16'h1234);
        hw(3'h3, 8'h80);
        hr(3'h0, 8'h34);
        hw(3'h4, 8'h77);
        hr(3'h4, 8'h00);
        hw(3'h3, 8'hc3);
        hr(3'h1, 8'h12);
        hw(3'h3, 8'he4);
        hr(3'h0, 8'h51);
        hr(3'h1, 8'he4);
        hr(3'h2, 8'hc1);
        hr(3'h3, 8'he4);
    endtask
    // Mode dependent masks, scratch, aux status, extended controls and levels.
    task automatic t_ext;
        hw(3'h3, 8'h00);
        hw(3'h1, 8'hff);
        hr(3'h1, 8'h0f);
        hw(3'h4, 8'hff);
        hr(3'h4, 8'h1f);
        hw(3'h7, 8'h5a);
        hr(3'h7, 8'h5a);
        hw(3'h3, 8'he0);
        hw(3'h2, 8'h01);
        hw(3'h4, 8'h30);
        hr(3'h4, 8'h30);
        hr(3'h6, 8'h00);
        hr(3'h7, 8'h03);
        hw(3'h3, 8'h00);
        hr(3'h1, 8'h2f);
        hr(3'h4, 8'h0b);
        hw(3'h7, 8'ha5);
        chk(aux, 8'ha5);
        tout = 1'b1;
        hr(3'h7, 8'h01);
        chk({ien, mmc}, 16'hffff);
        hw(3'h3, 8'he0);
        hw(3'h2, 8'h00);
        chk(ex1, 8'h00);
        hw(3'h3, 8'h00);
        hr(3'h7, 8'h5a);
    endtask
    // Transmit bytes written every other cycle against a stalling engine.
    task automatic t_tx;
        hw(3'h3, 8'h00);
        slow = 1'b1;
        hw(3'h0, 8'ha1);
        hw(3'h0, 8'ha2);
        hw(3'h0, 8'ha3);
        for (int i = 0; i < 60 && last_tx !== 8'ha3; i++) @(negedge clk);
        chk(last_tx, 8'ha3);
    endtask
    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_bank0();
        t_banks();
        t_ext();
        t_tx();
        stop_test();
    end
endmodule
